// File: core/cyclic_timer_switch_shutdown.sv
`timescale 1ns/1ps
// Contract
// RULE_01: on-time codes 000 stop timer low; 001..101 give 0.1,0.3,1,10,20 ms.
// RULE_02: on-time code 110 stops timer and holds assigned switch high.
// RULE_03: reserved on-time code 111 acts exactly like 110.
// RULE_04: period codes give 10,20,50,100,200,500 ms, then 1 s and 2 s.
// RULE_05: timer control field layout; bits 12 and 3 read zero.
// RULE_06: wake select bits 8:7: 00 none, 01 timer1, 10 timer2, 11 reserved.
// RULE_07: timer control clears on power-on, soft reset and restart entry.
// RULE_08: an assigned timer starts once a running on-time is written.
// RULE_09: switch assignment cleared in restart also clears that timer's settings.
// RULE_10: failures without restart leave timer settings untouched.
// RULE_11: cyclic sense and cyclic wake run together on one timer.
// RULE_12: per-switch overvoltage recovery: 0 stays off, 1 resumes prior state.
// RULE_13: bit 11 picks overtemperature shutdown of all switches or only affected.
// RULE_14: per-switch overvoltage shutdown disable keeps switch on in normal mode.
// RULE_15: undervoltage recovery bit 3 restores switches after undervoltage ends.
// RULE_16: source code 0010 follows timer1, 0011 follows timer2.
// RULE_17: timer wake filter samples wake input with 16 us at on-time end.
// RULE_18: running timer drives high for on-time at start of each period.
// RULE_19: hardware clearing of timer fields is visible on read-back.
module cyclic_timer_switch_shutdown #(
	parameter int unsigned TICK_CYCLES = cyclic_timer_pkg::TICK_CYCLES_DFLT
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic SOFT_RST,
	input wire logic RESTART_ENTRY,
	input wire logic RESTART_MODE,
	input wire logic NORMAL_MODE,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [6:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	input wire logic [15:0] HS_SOURCE,
	input wire logic [2:0] WAKE_FILTER_SELECT,
	input wire logic WAKE_IN,
	input wire logic SUPPLY_OV,
	input wire logic SUPPLY_UV,
	input wire logic [3:0] SWITCH_OT,
	output logic [3:0] HS_DRIVE,
	output logic CYCLIC_WAKE,
	output logic WAKE_SAMPLED
);
	localparam int unsigned NS = 7;
	localparam int unsigned CW = cyclic_timer_pkg::CNT_W;

	logic [15:0] tctl_ff;
	logic [15:0] sdctl_ff;
	logic [15:0] rdata_ff;
	logic [NS-1:0] sync1_ff;
	logic [NS-1:0] sync2_ff;
	logic [31:0] pre_ff;
	logic tick;
	logic [15:0] src_prev_ff;
	logic [3:0] ov_off_ff;
	logic [3:0] uv_off_ff;
	logic [3:0] drive_ff;
	logic cwake_ff;
	logic wsamp_ff;
	logic [cyclic_timer_pkg::FILT_W-1:0] filt_ff;
	logic wake_s, ov_s, uv_s;
	logic [3:0] ot_s;
	logic [2:0] on1, on2, per1, per2;
	logic [1:0] wsel;
	logic [1:0] assigned;
	logic [1:0] unassigned;
	logic run1, run2, lvl1, lvl2, end1, end2;
	logic hold1, hold2;
	logic [3:0] req;
	logic [3:0] ot_off;

	assign on1 = tctl_ff[cyclic_timer_pkg::T1_ON_LSB +: 3];
	assign on2 = tctl_ff[cyclic_timer_pkg::T2_ON_LSB +: 3];
	assign per1 = tctl_ff[cyclic_timer_pkg::T1_PER_LSB +: 3];
	assign per2 = tctl_ff[cyclic_timer_pkg::T2_PER_LSB +: 3];
	assign wsel = tctl_ff[cyclic_timer_pkg::WAKE_SEL_LSB +: 2];
	assign {ot_s, uv_s, ov_s, wake_s} = sync2_ff;

	// pins come from the analog side, so two flops before use
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {SWITCH_OT, SUPPLY_UV, SUPPLY_OV, WAKE_IN};
			sync2_ff <= sync1_ff;
		end
	end

	always_comb begin
		assigned = 2'b00;
		unassigned = 2'b00;
		for (int i = 0; i < 4; i++) begin
			if (HS_SOURCE[4*i +: 4] == cyclic_timer_pkg::SRC_TIMER1) assigned[0] = 1'b1;
			if (HS_SOURCE[4*i +: 4] == cyclic_timer_pkg::SRC_TIMER2) assigned[1] = 1'b1;
			// assignment dropped while restarting
			if (src_prev_ff[4*i +: 4] == cyclic_timer_pkg::SRC_TIMER1 &&
					HS_SOURCE[4*i +: 4] != cyclic_timer_pkg::SRC_TIMER1) unassigned[0] = 1'b1;
			if (src_prev_ff[4*i +: 4] == cyclic_timer_pkg::SRC_TIMER2 &&
					HS_SOURCE[4*i +: 4] != cyclic_timer_pkg::SRC_TIMER2) unassigned[1] = 1'b1;
		end
	end

	// register file; hardware clears take priority over a software write
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tctl_ff <= cyclic_timer_pkg::TIMER_CTRL_RESET; // RULE_07
			sdctl_ff <= cyclic_timer_pkg::SHUTDOWN_CTRL_RESET;
			src_prev_ff <= '0;
		end else begin
			src_prev_ff <= HS_SOURCE;
			if (SOFT_RST) begin
				tctl_ff <= cyclic_timer_pkg::TIMER_CTRL_RESET; // RULE_07
				sdctl_ff <= cyclic_timer_pkg::SHUTDOWN_CTRL_RESET;
			end else if (RESTART_ENTRY) begin
				// only restart touches the timer fields; other faults do not
				tctl_ff <= cyclic_timer_pkg::TIMER_CTRL_RESET; // RULE_07 RULE_10
			end else begin
				if (REG_WR && REG_ADDR == cyclic_timer_pkg::TIMER_CTRL_ADDR) begin
					tctl_ff <= REG_WDATA & cyclic_timer_pkg::TIMER_CTRL_MASK; // RULE_05
				end
				if (REG_WR && REG_ADDR == cyclic_timer_pkg::SHUTDOWN_CTRL_ADDR) begin
					sdctl_ff <= REG_WDATA & cyclic_timer_pkg::SHUTDOWN_CTRL_MASK;
				end
				if (RESTART_MODE && unassigned[0]) begin
					tctl_ff[cyclic_timer_pkg::T1_ON_LSB +: 3] <= 3'h0; // RULE_09 RULE_19
					tctl_ff[cyclic_timer_pkg::T1_PER_LSB +: 3] <= 3'h0; // RULE_09
				end
				if (RESTART_MODE && unassigned[1]) begin
					tctl_ff[cyclic_timer_pkg::T2_ON_LSB +: 3] <= 3'h0; // RULE_09 RULE_19
					tctl_ff[cyclic_timer_pkg::T2_PER_LSB +: 3] <= 3'h0; // RULE_09
				end
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_ff <= 16'h0000;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				cyclic_timer_pkg::TIMER_CTRL_ADDR: rdata_ff <= tctl_ff; // RULE_19
				cyclic_timer_pkg::SHUTDOWN_CTRL_ADDR: rdata_ff <= sdctl_ff;
				default: rdata_ff <= 16'h0000;
			endcase
		end
	end

	// shared 100 us prescaler keeps both timers on one grid
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pre_ff <= '0;
		end else begin
			pre_ff <= tick ? '0 : pre_ff + 32'd1;
		end
	end
	assign tick = (pre_ff == TICK_CYCLES - 1);

	assign hold1 = (on1 == cyclic_timer_pkg::ON_OFF_HIGH) || (on1 == cyclic_timer_pkg::ON_RESERVED);
	assign hold2 = (on2 == cyclic_timer_pkg::ON_OFF_HIGH) || (on2 == cyclic_timer_pkg::ON_RESERVED);
	// running code plus a user: a switch or the wake logic
	assign run1 = (on1 != cyclic_timer_pkg::ON_OFF_LOW) && !hold1 &&
			(assigned[0] || wsel == cyclic_timer_pkg::WAKE_SEL_T1); // RULE_08 RULE_11
	assign run2 = (on2 != cyclic_timer_pkg::ON_OFF_LOW) && !hold2 &&
			(assigned[1] || wsel == cyclic_timer_pkg::WAKE_SEL_T2); // RULE_08 RULE_11

	cyclic_timer #(.W(CW)) u_timer1 (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.tick(tick),
		.run(run1),
		.on_len(cyclic_timer_pkg::on_ticks(on1)), // RULE_01
		.per_len(cyclic_timer_pkg::per_ticks(per1)), // RULE_04
		.level(lvl1), // RULE_18
		.on_end(end1)
	);

	cyclic_timer #(.W(CW)) u_timer2 (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.tick(tick),
		.run(run2),
		.on_len(cyclic_timer_pkg::on_ticks(on2)), // RULE_01
		.per_len(cyclic_timer_pkg::per_ticks(per2)), // RULE_04
		.level(lvl2), // RULE_18
		.on_end(end2)
	);

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			unique case (HS_SOURCE[4*i +: 4])
				cyclic_timer_pkg::SRC_ON: req[i] = 1'b1;
				cyclic_timer_pkg::SRC_TIMER1: req[i] = hold1 || lvl1; // RULE_16 RULE_02 RULE_03
				cyclic_timer_pkg::SRC_TIMER2: req[i] = hold2 || lvl2; // RULE_16 RULE_02 RULE_03
				default: req[i] = 1'b0;
			endcase
		end
		ot_off = sdctl_ff[cyclic_timer_pkg::OT_INDIV_BIT] ? ot_s : {4{|ot_s}}; // RULE_13
	end

	// shutdown latches; a switch set to off releases its latch
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ov_off_ff <= 4'h0;
			uv_off_ff <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ov_s && !(NORMAL_MODE ? sdctl_ff[cyclic_timer_pkg::OV_SDN_DIS_LSB + i]
						: sdctl_ff[cyclic_timer_pkg::OV_SDS_DIS_BIT])) begin
					ov_off_ff[i] <= 1'b1; // RULE_14
				end else if (!ov_s && sdctl_ff[cyclic_timer_pkg::OV_REC_LSB + i]) begin
					ov_off_ff[i] <= 1'b0; // RULE_12
				end else if (HS_SOURCE[4*i +: 4] == cyclic_timer_pkg::SRC_OFF) begin
					ov_off_ff[i] <= 1'b0;
				end
				if (uv_s && !sdctl_ff[cyclic_timer_pkg::UV_SD_DIS_BIT]) begin
					uv_off_ff[i] <= 1'b1;
				end else if (!uv_s && sdctl_ff[cyclic_timer_pkg::UV_REC_BIT]) begin
					uv_off_ff[i] <= 1'b0; // RULE_15
				end else if (HS_SOURCE[4*i +: 4] == cyclic_timer_pkg::SRC_OFF) begin
					uv_off_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			drive_ff <= 4'h0;
		end else begin
			drive_ff <= req & ~ov_off_ff & ~uv_off_ff & ~ot_off; // RULE_13
		end
	end

	// wake input must have been high for the filter time at on-time end
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			filt_ff <= '0;
			cwake_ff <= 1'b0;
			wsamp_ff <= 1'b0;
		end else begin
			if (!wake_s) begin
				filt_ff <= '0;
			end else if (filt_ff < cyclic_timer_pkg::FILT_W'(cyclic_timer_pkg::WAKE_FILT_CYCLES)) begin
				filt_ff <= filt_ff + 1'b1;
			end
			cwake_ff <= (wsel == cyclic_timer_pkg::WAKE_SEL_T1 && end1) ||
					(wsel == cyclic_timer_pkg::WAKE_SEL_T2 && end2); // RULE_06 RULE_11
			wsamp_ff <= ((WAKE_FILTER_SELECT == cyclic_timer_pkg::FILT_SEL_T1 && end1) ||
					(WAKE_FILTER_SELECT == cyclic_timer_pkg::FILT_SEL_T2 && end2)) &&
					(filt_ff >= cyclic_timer_pkg::FILT_W'(cyclic_timer_pkg::WAKE_FILT_CYCLES)); // RULE_17
		end
	end

	assign REG_RDATA = rdata_ff;
	assign HS_DRIVE = drive_ff;
	assign CYCLIC_WAKE = cwake_ff;
	assign WAKE_SAMPLED = wsamp_ff;

	a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_05
		tctl_ff[12] == 1'b0 && tctl_ff[3] == 1'b0 && sdctl_ff[4] == 1'b0)
		else $error("reserved bit set");
	a_restart_clears: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_07
		RESTART_ENTRY |=> tctl_ff == 16'h0000)
		else $error("timer control not cleared on restart");
	a_hold_high: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_02
		(HS_SOURCE[3:0] == cyclic_timer_pkg::SRC_TIMER1 && on1[2:1] == 2'b11 && $stable(HS_SOURCE)
		&& !ov_off_ff[0] && !uv_off_ff[0] && ot_off == 4'h0 && $stable(on1)) |=> HS_DRIVE[0])
		else $error("held-high timer did not drive switch");
	a_off_low_stops: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_01
		(on1 == cyclic_timer_pkg::ON_OFF_LOW) [*2] |-> !lvl1)
		else $error("stopped timer output high");
	a_no_fail_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_10
		(!SOFT_RST && !RESTART_ENTRY && !RESTART_MODE && !REG_WR) |=> $stable(tctl_ff))
		else $error("timer settings changed without restart");
	a_unassign_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_09
		(RESTART_MODE && unassigned[0] && !SOFT_RST && !RESTART_ENTRY) |=> on1 == 3'h0 && per1 == 3'h0)
		else $error("timer1 settings survived unassignment");
	a_ot_all: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_13
		(!sdctl_ff[cyclic_timer_pkg::OT_INDIV_BIT] && ot_s != 4'h0) |=> HS_DRIVE == 4'h0)
		else $error("overtemperature left a switch on");
	a_wake_source: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_06
		CYCLIC_WAKE |-> $past(wsel) == cyclic_timer_pkg::WAKE_SEL_T1 || $past(wsel) == cyclic_timer_pkg::WAKE_SEL_T2)
		else $error("cyclic wake without a timer source");
	a_ov_stays_off: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RULE_12
		(ov_off_ff[0] && !sdctl_ff[cyclic_timer_pkg::OV_REC_LSB] && HS_SOURCE[3:0] != 4'h0) |=> ov_off_ff[0])
		else $error("switch recovered without recovery enable");
endmodule : cyclic_timer_switch_shutdown

// File: core/cyclic_timer_pkg.sv
package cyclic_timer_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned TICK_US = 100;
	localparam int unsigned TICK_CYCLES_DFLT = TICK_US * CLK_MHZ;
	localparam int unsigned WAKE_FILT_US = 16;
	localparam int unsigned WAKE_FILT_CYCLES = WAKE_FILT_US * CLK_MHZ;
	localparam int unsigned CNT_W = 15;
	localparam int unsigned FILT_W = 12;

	localparam logic [6:0] TIMER_CTRL_ADDR = 7'h06;
	localparam logic [6:0] SHUTDOWN_CTRL_ADDR = 7'h07;
	localparam logic [15:0] TIMER_CTRL_RESET = 16'h0000;
	localparam logic [15:0] SHUTDOWN_CTRL_RESET = 16'h0000;
	localparam logic [15:0] TIMER_CTRL_MASK = 16'hEFF7;
	localparam logic [15:0] SHUTDOWN_CTRL_MASK = 16'hFFE8;

	localparam int unsigned T2_ON_LSB = 13;
	localparam int unsigned T2_PER_LSB = 9;
	localparam int unsigned WAKE_SEL_LSB = 7;
	localparam int unsigned T1_ON_LSB = 4;
	localparam int unsigned T1_PER_LSB = 0;
	localparam int unsigned OV_REC_LSB = 12;
	localparam int unsigned OT_INDIV_BIT = 11;
	localparam int unsigned OV_SDN_DIS_LSB = 7;
	localparam int unsigned OV_SDS_DIS_BIT = 6;
	localparam int unsigned UV_SD_DIS_BIT = 5;
	localparam int unsigned UV_REC_BIT = 3;

	localparam logic [2:0] ON_OFF_LOW = 3'h0;
	localparam logic [2:0] ON_OFF_HIGH = 3'h6;
	localparam logic [2:0] ON_RESERVED = 3'h7;
	localparam logic [1:0] WAKE_SEL_T1 = 2'h1;
	localparam logic [1:0] WAKE_SEL_T2 = 2'h2;
	localparam logic [2:0] FILT_SEL_T1 = 3'h2;
	localparam logic [2:0] FILT_SEL_T2 = 3'h3;
	localparam logic [3:0] SRC_OFF = 4'h0;
	localparam logic [3:0] SRC_ON = 4'h1;
	localparam logic [3:0] SRC_TIMER1 = 4'h2;
	localparam logic [3:0] SRC_TIMER2 = 4'h3;

	// on-time in 100 us ticks
	function automatic logic [CNT_W-1:0] on_ticks(input logic [2:0] code);
		unique case (code)
			3'h1: on_ticks = 15'h0001;
			3'h2: on_ticks = 15'h0003;
			3'h3: on_ticks = 15'h000A;
			3'h4: on_ticks = 15'h0064;
			3'h5: on_ticks = 15'h00C8;
			default: on_ticks = 15'h0000;
		endcase
	endfunction : on_ticks

	// period in 100 us ticks
	function automatic logic [CNT_W-1:0] per_ticks(input logic [2:0] code);
		unique case (code)
			3'h0: per_ticks = 15'h0064;
			3'h1: per_ticks = 15'h00C8;
			3'h2: per_ticks = 15'h01F4;
			3'h3: per_ticks = 15'h03E8;
			3'h4: per_ticks = 15'h07D0;
			3'h5: per_ticks = 15'h1388;
			3'h6: per_ticks = 15'h2710;
			3'h7: per_ticks = 15'h4E20;
		endcase
	endfunction : per_ticks
endpackage : cyclic_timer_pkg

// File: core/cyclic_timer.sv
`timescale 1ns/1ps
module cyclic_timer #(
	parameter int unsigned W = 15
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic run,
	input wire logic [W-1:0] on_len,
	input wire logic [W-1:0] per_len,
	output logic level,
	output logic on_end
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic level_ff;
	logic on_end_ff;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (!run) begin
			nxt_cnt = '0;
		end else if (tick) begin
			nxt_cnt = (cnt_ff >= per_len - W'(1)) ? '0 : cnt_ff + W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			level_ff <= 1'b0;
			on_end_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			level_ff <= run && (nxt_cnt < on_len);
			on_end_ff <= run && tick && (cnt_ff == on_len - W'(1));
		end
	end

	assign level = level_ff;
	assign on_end = on_end_ff;

	a_on_end_falls: assert property (@(posedge clk) disable iff (!rst_n)
		(on_end && run && on_len < per_len) |-> !level)
		else $error("on-time end while output still high");
endmodule : cyclic_timer

// File: bench/host_model.sv
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [6:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 16'h0000;
	end

	// released lines show the inverse so stale values never pass for live ones
	task automatic wr(input logic [6:0] addr, input logic [15:0] data);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = addr;
		reg_wdata = data;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~addr;
		reg_wdata = ~data;
	endtask : wr

	task automatic rd(input logic [6:0] addr, output logic [15:0] data);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = addr;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~addr;
		data = reg_rdata;
	endtask : rd
endmodule : host_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int TICK = 10;
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic SOFT_RST = 1'b0;
	logic RESTART_ENTRY = 1'b0;
	logic RESTART_MODE = 1'b0;
	logic NORMAL_MODE = 1'b1;
	logic REG_WR, REG_RD;
	logic [6:0] REG_ADDR;
	logic [15:0] REG_WDATA, REG_RDATA;
	logic [15:0] HS_SOURCE = 16'h0000;
	logic [2:0] WAKE_FILTER_SELECT = 3'h2;
	logic WAKE_IN = 1'b1;
	logic SUPPLY_OV = 1'b0;
	logic SUPPLY_UV = 1'b0;
	logic [3:0] SWITCH_OT = 4'h0;
	logic [3:0] HS_DRIVE;
	logic CYCLIC_WAKE, WAKE_SAMPLED;
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n_hi, n_wk, n_ws;
	int on_t[5] = '{1, 3, 10, 100, 200};
	logic [15:0] rv;

	always #5 REF_CLK = ~REF_CLK;

	cyclic_timer_switch_shutdown #(.TICK_CYCLES(TICK)) cyclic_timer_switch_shutdown_i (
		.REF_CLK, .RST_N, .SOFT_RST, .RESTART_ENTRY, .RESTART_MODE, .NORMAL_MODE,
		.REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .HS_SOURCE,
		.WAKE_FILTER_SELECT, .WAKE_IN, .SUPPLY_OV, .SUPPLY_UV, .SWITCH_OT,
		.HS_DRIVE, .CYCLIC_WAKE, .WAKE_SAMPLED
	);

	host_model host_model_i (
		.clk(REF_CLK), .reg_wr(REG_WR), .reg_rd(REG_RD), .reg_addr(REG_ADDR),
		.reg_wdata(REG_WDATA), .reg_rdata(REG_RDATA)
	);

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic measure(input int n, input int idx);
		n_hi = 0;
		n_wk = 0;
		n_ws = 0;
		repeat (n) begin
			@(negedge REF_CLK);
			n_hi += HS_DRIVE[idx];
			n_wk += CYCLIC_WAKE;
			n_ws += WAKE_SAMPLED;
		end
	endtask : measure

	task automatic drive_is(input string what, input logic [3:0] exp);
		measure(6, 0);
		chk(what, {12'h000, exp}, {12'h000, HS_DRIVE});
	endtask : drive_is

	task automatic test_done;
		$display("checks %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// longest path is the on-time sweep, about 50k cycles
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 80000) begin
			error_cnt++;
			test_done();
		end
	end

	initial begin
		repeat (3) @(negedge REF_CLK);
		RST_N = 1'b1;
		@(negedge REF_CLK);
		host_model_i.rd(7'h06, rv); chk("timer ctrl reset", 16'h0000, rv);
		host_model_i.rd(7'h07, rv); chk("shutdown ctrl reset", 16'h0000, rv);
		host_model_i.wr(7'h06, 16'hFFFF);
		host_model_i.rd(7'h06, rv); chk("timer ctrl fields", 16'hEFF7, rv);
		host_model_i.wr(7'h07, 16'hFFFF);
		host_model_i.rd(7'h07, rv); chk("shutdown ctrl fields", 16'hFFE8, rv);
		host_model_i.rd(7'h05, rv); chk("unmapped read", 16'h0000, rv);
		SOFT_RST = 1'b1;
		@(negedge REF_CLK);
		SOFT_RST = 1'b0;
		host_model_i.rd(7'h06, rv); chk("soft reset timer", 16'h0000, rv);
		host_model_i.rd(7'h07, rv); chk("soft reset shutdown", 16'h0000, rv);
		host_model_i.wr(7'h06, 16'h0012);
		RESTART_ENTRY = 1'b1;
		@(negedge REF_CLK);
		RESTART_ENTRY = 1'b0;
		host_model_i.rd(7'h06, rv); chk("restart entry", 16'h0000, rv);

		// switch1 on timer1, period 50 ms, timer1 also the wake source
		HS_SOURCE = 16'h0002;
		for (int c = 1; c <= 5; c++) begin
			// wake pin low for one pass so a stuck-open filter shows up
			WAKE_IN = (c != 4);
			host_model_i.wr(7'h06, 16'h0082);
			host_model_i.wr(7'h06, 16'h0082 | 16'(c << 4));
			measure(5000, 0);
			measure(5000, 0);
			chk("switch1 on cycles", 16'(on_t[c-1] * TICK), 16'(n_hi));
			chk("cyclic wake pulses", 16'h0001, 16'(n_wk));
			chk("wake samples", 16'(c != 4), 16'(n_ws));
		end
		for (int c = 6; c <= 8; c++) begin
			host_model_i.wr(7'h06, 16'((c & 7) << 4));
			measure(5, 0);
			measure(50, 0);
			chk("switch1 held", 16'(c < 8 ? 50 : 0), 16'(n_hi));
		end

		// switch2 on timer2, period 10 ms, no wake source; switch1 keeps timer1
		HS_SOURCE = 16'h0032;
		host_model_i.wr(7'h06, 16'h2012);
		measure(1000, 1);
		measure(1000, 1);
		chk("switch2 on cycles", 16'(on_t[0] * TICK), 16'(n_hi));
		chk("no wake pulses", 16'h0000, 16'(n_wk));
		SUPPLY_OV = 1'b1;
		measure(10, 1);
		SUPPLY_OV = 1'b0;
		host_model_i.rd(7'h06, rv); chk("kept after fault", 16'h2012, rv);
		RESTART_MODE = 1'b1;
		HS_SOURCE = 16'h0000;
		measure(5, 1);
		host_model_i.rd(7'h06, rv); chk("cleared on unassign", 16'h0000, rv);
		RESTART_MODE = 1'b0;

		HS_SOURCE = 16'h1111;
		drive_is("all on", 4'hF);
		SWITCH_OT = 4'h1;
		drive_is("ot all off", 4'h0);
		host_model_i.wr(7'h07, 16'h0800);
		drive_is("ot individual", 4'hE);
		SWITCH_OT = 4'h0;
		host_model_i.wr(7'h07, 16'h2080);
		drive_is("ot cleared", 4'hF);
		SUPPLY_OV = 1'b1;
		drive_is("ov shutdown", 4'h1);
		SUPPLY_OV = 1'b0;
		drive_is("ov recovery", 4'h3);
		HS_SOURCE = 16'h0000;
		measure(4, 0);
		HS_SOURCE = 16'h1111;
		host_model_i.wr(7'h07, 16'h0008);
		SUPPLY_UV = 1'b1;
		drive_is("uv shutdown", 4'h0);
		SUPPLY_UV = 1'b0;
		drive_is("uv recovery", 4'hF);
		// outside normal mode only the shared stop/sleep bit counts
		NORMAL_MODE = 1'b0;
		host_model_i.wr(7'h07, 16'h0040);
		SUPPLY_OV = 1'b1;
		drive_is("ov stop mode kept", 4'hF);
		host_model_i.wr(7'h07, 16'h0080);
		drive_is("ov stop mode shutdown", 4'h0);
		SUPPLY_OV = 1'b0;
		NORMAL_MODE = 1'b1;
		test_done();
	end
endmodule : tb_top
